// file: design/eag_pkg.sv
// eag_pkg: shared types and constants for the effective address generator
// assumes a 16-bit data space and 24-bit program space
package eag_pkg;

    localparam int DATA_W        = 16;
    localparam int PROG_W        = 24;
    localparam int NEAR_W        = 13;
    localparam int REG_SEL_W     = 4;
    localparam int LIT5_W        = 5;
    localparam int LIT10_W       = 10;
    localparam int LIT16_W       = 16;
    localparam int LIT14_W       = 14;
    localparam int PAGE_W        = 8;
    localparam int WIN_LOW_W     = 15;
    localparam int WIN_ENA_BIT   = 2;
    localparam int DATA_MSB      = 15;
    localparam int PAGE_MSB      = 7;
    localparam int NEAR_BYTES    = 8192;
    localparam logic [3:0] DEFAULT_WORK_IDX = 4'h0;
    localparam logic [15:0] ZERO_ADDR = 16'h0000;
    localparam logic [23:0] ZERO_PADDR = 24'h000000;

    typedef enum logic [3:0] {
        EAG_MODE_NONE,
        EAG_MODE_IMPLIED,
        EAG_MODE_FILE,
        EAG_MODE_REG_DIRECT,
        EAG_MODE_INDIRECT,
        EAG_MODE_POST_MOD,
        EAG_MODE_PRE_MOD,
        EAG_MODE_INDEXED,
        EAG_MODE_LIT_OFFSET,
        EAG_MODE_LITERAL
    } eag_mode_e;

    typedef enum logic [2:0] {
        EAG_OP_GENERAL,
        EAG_OP_MOVE,
        EAG_OP_THREE,
        EAG_OP_BRANCH,
        EAG_OP_DEFER,
        EAG_OP_TABLE,
        EAG_OP_NOP
    } eag_op_e;

    typedef enum logic [1:0] {
        EAG_LIT_5,
        EAG_LIT_10,
        EAG_LIT_16
    } eag_lit_e;

    // one decoded instruction from the decoder
    typedef struct packed {
        logic                 valid;
        eag_op_e              op;
        eag_mode_e            src_mode;
        eag_mode_e            dst_mode;
        logic [3:0]           src_reg;
        logic [3:0]           dst_reg;
        logic [3:0]           base_reg;
        logic [12:0]          file_addr;
        logic [15:0]          full_addr;
        logic                 file_to_work;
        logic [15:0]          literal;
        eag_lit_e             lit_size;
        logic signed [15:0]   modify;
        logic                 table_high;
    } eag_req_s;

    typedef struct packed {
        logic        valid;
        logic        src_valid;
        logic [15:0] src_addr;
        logic        src_is_reg;
        logic [3:0]  src_reg;
        logic        src_is_lit;
        logic [15:0] src_lit;
        logic        dst_valid;
        logic [15:0] dst_addr;
        logic        dst_is_reg;
        logic [3:0]  dst_reg;
        logic [3:0]  base_reg;
        logic        wb_valid;
        logic [3:0]  wb_reg;
        logic [15:0] wb_value;
    } eag_data_s;

    typedef struct packed {
        logic        valid;
        logic [23:0] addr;
        logic        config_space;
        logic        high_byte;
        logic        read_only;
        logic        low_word_only;
    } eag_prog_s;

endpackage : eag_pkg

// file: design/eag_remap.sv
// eag_remap: program-space address forming for table and window accesses
// assumes page registers are stable while a request is presented
`timescale 1ns/1ps
`default_nettype none
module eag_remap (
    input  wire logic [15:0] data_ea,
    input  wire logic        is_table,
    input  wire logic        table_high,
    input  wire logic [7:0]  table_page,
    input  wire logic [7:0]  window_page,
    input  wire logic        window_enable,
    output eag_pkg::eag_prog_s prog
);
    import eag_pkg::*;

    logic win_hit;

    always_comb begin
        win_hit = window_enable && data_ea[DATA_MSB];
        prog    = '0;
        if (is_table) begin
            prog.valid        = 1'b1;
            prog.addr         = {table_page, data_ea};
            prog.config_space = table_page[PAGE_MSB];
            prog.high_byte    = table_high;
        end else if (win_hit) begin
            prog.valid         = 1'b1;
            // data bit 15 dropped; page bit 0 lands in program bit 15
            prog.addr          = {1'b0, window_page, data_ea[WIN_LOW_W-1:0]};
            prog.read_only     = 1'b1;
            prog.low_word_only = 1'b1;
        end
    end

endmodule : eag_remap
`default_nettype wire

// file: design/eag_top.sv
// eag_top: effective address generator for a 16-bit core
// assumes a decoder supplies one request a cycle and working registers are read combinationally
//
// Behaviour
// - direct file operands take a 13-bit field, reaching the first 8192 bytes
// - file operations use W0 as second operand; result to file or W0
// - move reaches the whole data space with its file address
// - three-operand first source is always a working register, direct
// - second source is register, memory or 5-bit literal; result register or memory
// - general ops use direct, indirect, post, pre modes and 5 or 10-bit literals
// - plain indirect uses pointer unchanged as address
// - post-modify uses pointer then steps it by a constant
// - pre-modify adds signed constant, writes back, uses new value
// - indexed address is pointer plus base register
// - literal-offset address is pointer plus instruction literal
// - move source and destination modes differ but share one 4-bit base field
// - branch takes 16-bit signed literal; defer takes 14-bit unsigned literal
// - implied operands carry no address; no-operation makes no address
// - table address is 8-bit table page above 16-bit data address
// - table page top bit selects user or configuration memory
// - window forms 23-bit address from visibility page and low 15 bits
// - window accesses drive program bit 23 low
// - window ignores data bit 15; program bit 15 from page bit 0
// - window is read-only and returns only the low word
// - table accesses reach every byte including the upper byte
// - window only when enable bit set and data top bit one
`timescale 1ns/1ps
`default_nettype none
module eag_top (
    input  wire logic               core_clk,
    input  wire logic               nrst,
    input  wire eag_pkg::eag_req_s  req,
    input  wire logic [15:0]        src_ptr_val,
    input  wire logic [15:0]        dst_ptr_val,
    input  wire logic [15:0]        base_val,
    input  wire logic [7:0]         table_page_reg,
    input  wire logic [7:0]         visibility_page_reg,
    input  wire logic [15:0]        core_control_reg,
    output eag_pkg::eag_data_s      data_out,
    output eag_pkg::eag_prog_s      prog_out
);
    import eag_pkg::*;

    // ------------------------------------------------------------
    // address arithmetic
    // ------------------------------------------------------------
    // plain 16-bit adder: carries out of bit 15 are discarded on purpose
    function automatic logic [15:0] wrap_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0];
    endfunction : wrap_add

    function automatic logic [15:0] lit_extend(input logic [15:0] lit, input eag_lit_e size);
        logic [15:0] r;
        r = 16'h0000;
        case (size)
            EAG_LIT_5:  r = {11'h000, lit[LIT5_W-1:0]};
            EAG_LIT_10: r = {6'h00, lit[LIT10_W-1:0]};
            default:    r = lit;
        endcase
        return r;
    endfunction : lit_extend

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic        is_reg;
        logic        is_lit;
        logic        wb;
        logic [15:0] wb_val;
    } eag_side_s;

    // one operand side; mode decides address and pointer update
    function automatic eag_side_s side_ea(input eag_mode_e mode, input logic [15:0] ptr,
                                          input logic [15:0] base, input eag_req_s r,
                                          input logic whole_space);
        eag_side_s s;
        logic [15:0] stepped;
        s       = '0;
        stepped = wrap_add(ptr, r.modify);
        case (mode)
            EAG_MODE_FILE: begin
                s.valid = 1'b1;
                if (whole_space)
                    s.addr = r.full_addr;
                else
                    s.addr = {3'h0, r.file_addr};
            end
            EAG_MODE_REG_DIRECT: begin
                s.is_reg = 1'b1;
            end
            EAG_MODE_INDIRECT: begin
                s.valid = 1'b1;
                s.addr  = ptr;
            end
            EAG_MODE_POST_MOD: begin
                s.valid  = 1'b1;
                s.addr   = ptr;
                s.wb     = 1'b1;
                s.wb_val = stepped;
            end
            EAG_MODE_PRE_MOD: begin
                s.valid  = 1'b1;
                s.addr   = stepped;
                s.wb     = 1'b1;
                s.wb_val = stepped;
            end
            EAG_MODE_INDEXED: begin
                s.valid = 1'b1;
                s.addr  = wrap_add(ptr, base);
            end
            EAG_MODE_LIT_OFFSET: begin
                s.valid = 1'b1;
                s.addr  = wrap_add(ptr, r.literal);
            end
            EAG_MODE_LITERAL: begin
                s.is_lit = 1'b1;
            end
            default: begin
                s = '0;
            end
        endcase
        return s;
    endfunction : side_ea

    // ------------------------------------------------------------
    // mode legality per operation class
    // ------------------------------------------------------------
    function automatic logic mode_ok(input eag_op_e op, input eag_mode_e m, input logic is_src);
        logic ok;
        ok = 1'b0;
        case (op)
            EAG_OP_MOVE: begin
                ok = (m != EAG_MODE_IMPLIED);
            end
            EAG_OP_GENERAL, EAG_OP_THREE: begin
                ok = (m == EAG_MODE_FILE) || (m == EAG_MODE_REG_DIRECT) || (m == EAG_MODE_INDIRECT) ||
                     (m == EAG_MODE_POST_MOD) || (m == EAG_MODE_PRE_MOD) ||
                     (is_src && m == EAG_MODE_LITERAL) || (m == EAG_MODE_NONE) ||
                     (m == EAG_MODE_IMPLIED);
            end
            EAG_OP_TABLE: begin
                ok = (m == EAG_MODE_INDIRECT) || (m == EAG_MODE_POST_MOD) ||
                     (m == EAG_MODE_PRE_MOD) || (m == EAG_MODE_REG_DIRECT) || (m == EAG_MODE_NONE);
            end
            default: begin
                ok = (m == EAG_MODE_NONE) || (m == EAG_MODE_IMPLIED) || (m == EAG_MODE_LITERAL);
            end
        endcase
        return ok;
    endfunction : mode_ok

    // ------------------------------------------------------------
    // combinational forming
    // ------------------------------------------------------------
    eag_side_s  src_side;
    eag_side_s  dst_side;
    eag_data_s  next_data;
    eag_prog_s  remap_prog;
    logic       legal;
    logic       is_file_op;
    logic       is_table;
    logic       win_en;
    logic [15:0] prog_ea;
    logic [15:0] op_lit;

    assign win_en   = core_control_reg[WIN_ENA_BIT];
    assign is_table = req.valid && (req.op == EAG_OP_TABLE);
    assign legal    = mode_ok(req.op, req.src_mode, 1'b1) && mode_ok(req.op, req.dst_mode, 1'b0);

    always_comb begin
        is_file_op = (req.src_mode == EAG_MODE_FILE) && (req.op != EAG_OP_MOVE);
        src_side   = side_ea(req.src_mode, src_ptr_val, base_val, req, req.op == EAG_OP_MOVE);
        dst_side   = side_ea(req.dst_mode, dst_ptr_val, base_val, req, req.op == EAG_OP_MOVE);
        op_lit     = lit_extend(req.literal, req.lit_size);
        case (req.op)
            EAG_OP_THREE:  op_lit = lit_extend(req.literal, EAG_LIT_5);
            EAG_OP_BRANCH: op_lit = req.literal;
            EAG_OP_DEFER:  op_lit = {2'h0, req.literal[LIT14_W-1:0]};
            default:       op_lit = op_lit;
        endcase
        next_data = '0;
        if (req.valid && legal && req.op != EAG_OP_NOP) begin
            next_data.valid      = 1'b1;
            next_data.src_valid  = src_side.valid;
            next_data.src_addr   = src_side.addr;
            next_data.src_is_reg = src_side.is_reg;
            next_data.src_reg    = req.src_reg;
            next_data.src_is_lit = src_side.is_lit;
            next_data.src_lit    = op_lit;
            next_data.dst_valid  = dst_side.valid;
            next_data.dst_addr   = dst_side.addr;
            next_data.dst_is_reg = dst_side.is_reg;
            next_data.dst_reg    = req.dst_reg;
            next_data.base_reg   = req.base_reg;
            if (is_file_op) begin
                // second operand is W0; result back to file or W0
                next_data.base_reg = DEFAULT_WORK_IDX;
                if (req.file_to_work) begin
                    next_data.dst_valid  = 1'b0;
                    next_data.dst_is_reg = 1'b1;
                    next_data.dst_reg    = DEFAULT_WORK_IDX;
                end else begin
                    next_data.dst_valid = 1'b1;
                    next_data.dst_addr  = src_side.addr;
                end
            end
            // single write port: source update wins, destination otherwise
            if (src_side.wb) begin
                next_data.wb_valid = 1'b1;
                next_data.wb_reg   = req.src_reg;
                next_data.wb_value = src_side.wb_val;
            end else if (dst_side.wb) begin
                next_data.wb_valid = 1'b1;
                next_data.wb_reg   = req.dst_reg;
                next_data.wb_value = dst_side.wb_val;
            end
        end
    end

    // table and window both use the source address when it is valid, else the destination address
    always_comb begin
        prog_ea = src_side.valid ? src_side.addr : dst_side.addr;
    end

    eag_remap u_remap (
        .data_ea       (prog_ea),
        .is_table      (is_table),
        .table_high    (req.table_high),
        .table_page    (table_page_reg),
        .window_page   (visibility_page_reg),
        .window_enable (win_en && !is_table && next_data.valid &&
                        (src_side.valid || dst_side.valid)),
        .prog          (remap_prog)
    );

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst)
            data_out <= '0;
        else
            data_out <= next_data;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst)
            prog_out <= '0;
        else if (next_data.valid || is_table)
            prog_out <= remap_prog;
        else
            prog_out <= '0;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    near_region_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (req.valid && req.op == EAG_OP_GENERAL && req.src_mode == EAG_MODE_FILE) |=>
        (data_out.src_addr < 16'h2000)) else $error("near file address out of range");

    post_mod_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (req.valid && legal && req.src_mode == EAG_MODE_POST_MOD && req.op != EAG_OP_NOP) |=>
        (data_out.src_addr == $past(src_ptr_val) &&
         data_out.wb_value == $past(src_ptr_val) + $past(req.modify)))
        else $error("post modify address wrong");

    pre_mod_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (req.valid && legal && req.src_mode == EAG_MODE_PRE_MOD && req.op != EAG_OP_NOP) |=>
        (data_out.src_addr == data_out.wb_value && data_out.wb_valid &&
         data_out.src_addr == 16'($past(src_ptr_val) + $past(req.modify))))
        else $error("pre modify address not written back");

    indexed_sum_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (req.valid && legal && req.op == EAG_OP_MOVE && req.src_mode == EAG_MODE_INDEXED) |=>
        (data_out.src_addr == 16'($past(src_ptr_val) + $past(base_val))))
        else $error("indexed address wrong");

    nop_silent_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (req.valid && req.op == EAG_OP_NOP) |=> !data_out.valid)
        else $error("no-operation produced an address");

    table_addr_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (is_table && next_data.valid && src_side.valid) |=>
        (prog_out.addr == {$past(table_page_reg), data_out.src_addr} &&
         prog_out.config_space == prog_out.addr[23]))
        else $error("table address wrong");

    window_form_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (prog_out.valid && prog_out.read_only) |->
        (prog_out.addr[23] == 1'b0 && prog_out.low_word_only))
        else $error("window reached configuration space");

    window_gate_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (!win_en && !is_table) |=> !prog_out.valid)
        else $error("window active while disabled");

    cov_table: cover property (@(posedge core_clk) disable iff (!nrst) is_table ##1 prog_out.valid);
    cov_window: cover property (@(posedge core_clk) disable iff (!nrst) prog_out.valid && prog_out.read_only);
    cov_pre: cover property (@(posedge core_clk) disable iff (!nrst)
        req.valid && req.src_mode == EAG_MODE_PRE_MOD ##1 data_out.wb_valid);

endmodule : eag_top
`default_nettype wire

// file: tb/eag_default_work_reg_model.sv
// eag_default_work_reg_model: working register file that feeds pointer values to eag_top
// assumes reads are combinational and pointer writeback lands one edge after data_out shows it
`timescale 1ns/1ps
`default_nettype none
module eag_default_work_reg_model (
    input  wire logic               core_clk,
    input  wire eag_pkg::eag_req_s  req,
    input  wire eag_pkg::eag_data_s data_out,
    output logic [15:0]             src_ptr_val,
    output logic [15:0]             dst_ptr_val,
    output logic [15:0]             base_val
);
    import eag_pkg::*;

    logic [15:0] regs [16];

    initial begin
        for (int i = 0; i < 16; i++) begin
            regs[i] = 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // read ports and writeback
    // ------------------------------------------------------------
    assign src_ptr_val = regs[req.src_reg];
    assign dst_ptr_val = regs[req.dst_reg];
    assign base_val    = regs[req.base_reg];

    always @(posedge core_clk) begin
        if (data_out.valid && data_out.wb_valid) begin
            regs[data_out.wb_reg] <= data_out.wb_value;
        end
    end

    // bench preload; call clear of a clock edge so a pending writeback cannot undo it
    task automatic set_reg(input int n, input logic [15:0] v);
        regs[n] = v;
    endtask : set_reg

endmodule : eag_default_work_reg_model
`default_nettype wire

// file: tb/test_eag_top.sv
// test_eag_top: self-checking bench for the effective address generator
// assumes latency of one edge and inputs driven at the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, (g), (e)); end end
module test_eag_top;
    import eag_pkg::*;

    logic        core_clk;
    logic        nrst;
    eag_req_s    req;
    logic [15:0] src_ptr_val;
    logic [15:0] dst_ptr_val;
    logic [15:0] base_val;
    logic [7:0]  tpage;
    logic [7:0]  vpage;
    logic [15:0] ccr;
    eag_data_s   data_out;
    eag_prog_s   prog_out;
    int          mismatches;
    int          tests_run;
    int          cycles;

    eag_top u_dut (.core_clk(core_clk), .nrst(nrst), .req(req), .src_ptr_val(src_ptr_val),
        .dst_ptr_val(dst_ptr_val), .base_val(base_val), .table_page_reg(tpage),
        .visibility_page_reg(vpage), .core_control_reg(ccr), .data_out(data_out), .prog_out(prog_out));
    eag_default_work_reg_model u_default_work_reg (.core_clk(core_clk), .req(req), .data_out(data_out),
        .src_ptr_val(src_ptr_val), .dst_ptr_val(dst_ptr_val), .base_val(base_val));

    always #10 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    // the whole run is about 70 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            print_verdict();
        end
    end

    function automatic eag_req_s mk(input eag_op_e op, input eag_mode_e sm);
        eag_req_s r;
        r = '0;
        r.valid = 1'b1;
        r.op = op;
        r.src_mode = sm;
        return r;
    endfunction : mk

    // result is visible at the returning falling edge
    task automatic send(input eag_req_s r);
        @(negedge core_clk);
        req = r;
        @(negedge core_clk);
        req = '0;
    endtask : send

    // past the writeback edge of the previous request, back on a falling edge
    task automatic preload(input int n, input logic [15:0] v);
        @(posedge core_clk);
        @(negedge core_clk);
        u_default_work_reg.set_reg(n, v);
    endtask : preload

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_file();
        eag_req_s r;
        r = mk(EAG_OP_GENERAL, EAG_MODE_FILE);
        r.dst_mode = EAG_MODE_FILE;
        r.file_addr = 13'h1fff;
        r.full_addr = 16'hffff;
        r.base_reg = 4'h9;
        r.file_to_work = 1'b1;
        send(r);
        `CHK(data_out.src_addr, 16'h1fff)
        `CHK(data_out.base_reg, 4'h0)
        `CHK(data_out.dst_is_reg, 1'b1)
        `CHK(data_out.dst_reg, 4'h0)
        r.file_to_work = 1'b0;
        send(r);
        `CHK(data_out.dst_is_reg, 1'b0)
        `CHK(data_out.dst_addr, 16'h1fff)
        r.op = EAG_OP_MOVE;
        send(r);
        `CHK(data_out.src_addr, 16'hffff)
    endtask : t_file

    task automatic t_modes();
        eag_mode_e   md [5] = '{EAG_MODE_INDIRECT, EAG_MODE_POST_MOD, EAG_MODE_PRE_MOD,
                                EAG_MODE_INDEXED, EAG_MODE_LIT_OFFSET};
        logic [15:0] ea [5] = '{16'hfff0, 16'hfff0, 16'h0010, 16'h0020, 16'h0030};
        logic        wb [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        eag_req_s    r;
        u_default_work_reg.set_reg(5, 16'h0030);
        for (int i = 0; i < 5; i++) begin
            preload(3, 16'hfff0);
            r = mk(EAG_OP_MOVE, md[i]);
            r.src_reg = 4'h3;
            r.base_reg = 4'h5;
            r.modify = 16'sh0020;
            r.literal = 16'h0040;
            r.lit_size = EAG_LIT_10;
            send(r);
            `CHK(data_out.valid, 1'b1)
            `CHK(data_out.src_addr, ea[i])
            `CHK(data_out.wb_valid, wb[i])
            if (wb[i]) begin
                `CHK(data_out.wb_value, 16'h0010)
                `CHK(data_out.wb_reg, 4'h3)
            end
        end
        preload(4, 16'h1000);
        r = mk(EAG_OP_MOVE, EAG_MODE_REG_DIRECT);
        r.dst_mode = EAG_MODE_INDEXED;
        r.dst_reg = 4'h4;
        r.base_reg = 4'h5;
        send(r);
        `CHK(data_out.src_is_reg, 1'b1)
        `CHK(data_out.dst_valid, 1'b1)
        `CHK(data_out.dst_addr, 16'h1030)
        `CHK(data_out.base_reg, 4'h5)
        preload(3, 16'h0000);
        r = mk(EAG_OP_GENERAL, EAG_MODE_PRE_MOD);
        r.src_reg = 4'h3;
        r.modify = -16'sd2;
        send(r);
        `CHK(data_out.src_addr, 16'hfffe)
        r.src_mode = EAG_MODE_INDEXED;
        send(r);
        `CHK(data_out.valid, 1'b0)
        r = mk(EAG_OP_GENERAL, EAG_MODE_LITERAL);
        r.literal = 16'hffff;
        send(r);
        `CHK(data_out.src_lit, 16'h001f)
        r.lit_size = EAG_LIT_10;
        send(r);
        `CHK(data_out.src_lit, 16'h03ff)
    endtask : t_modes

    task automatic t_other();
        eag_req_s r;
        r = mk(EAG_OP_THREE, EAG_MODE_LITERAL);
        r.base_reg = 4'h2;
        r.dst_mode = EAG_MODE_REG_DIRECT;
        r.dst_reg = 4'h7;
        r.literal = 16'hffff;
        r.lit_size = EAG_LIT_10;
        send(r);
        `CHK(data_out.base_reg, 4'h2)
        `CHK(data_out.src_is_lit, 1'b1)
        `CHK(data_out.src_lit, 16'h001f)
        `CHK(data_out.dst_is_reg, 1'b1)
        `CHK(data_out.dst_reg, 4'h7)
        r = mk(EAG_OP_BRANCH, EAG_MODE_LITERAL);
        r.literal = 16'h8001;
        r.lit_size = EAG_LIT_16;
        send(r);
        `CHK(data_out.src_lit, 16'h8001)
        r.op = EAG_OP_DEFER;
        r.literal = 16'hffff;
        send(r);
        `CHK(data_out.src_lit, 16'h3fff)
        send(mk(EAG_OP_GENERAL, EAG_MODE_IMPLIED));
        `CHK(data_out.src_valid, 1'b0)
        send(mk(EAG_OP_NOP, EAG_MODE_NONE));
        `CHK(data_out.valid, 1'b0)
        `CHK(prog_out.valid, 1'b0)
    endtask : t_other

    task automatic t_prog();
        eag_req_s r;
        preload(3, 16'h8abc);
        ccr = 16'h0004;
        tpage = 8'h85;
        vpage = 8'ha5;
        r = mk(EAG_OP_TABLE, EAG_MODE_INDIRECT);
        r.src_reg = 4'h3;
        r.table_high = 1'b1;
        send(r);
        `CHK(prog_out.addr, 24'h858abc)
        `CHK(prog_out.config_space, 1'b1)
        `CHK(prog_out.high_byte, 1'b1)
        `CHK(prog_out.read_only, 1'b0)
        tpage = 8'h12;
        r.table_high = 1'b0;
        send(r);
        `CHK(prog_out.addr, 24'h128abc)
        `CHK(prog_out.config_space, 1'b0)
        u_default_work_reg.set_reg(3, 16'hf234);
        r = mk(EAG_OP_GENERAL, EAG_MODE_INDIRECT);
        r.src_reg = 4'h3;
        send(r);
        `CHK(prog_out.addr, {1'b0, 8'ha5, 15'h7234})
        `CHK(prog_out.read_only, 1'b1)
        `CHK(prog_out.low_word_only, 1'b1)
        ccr = 16'hfffb;
        send(r);
        `CHK(prog_out.valid, 1'b0)
        ccr = 16'h0004;
        u_default_work_reg.set_reg(3, 16'h7234);
        send(r);
        `CHK(prog_out.valid, 1'b0)
        ccr = 16'h0000;
    endtask : t_prog

    task automatic t_b2b_reset();
        eag_req_s r;
        u_default_work_reg.set_reg(3, 16'h1111);
        u_default_work_reg.set_reg(4, 16'h2222);
        r = mk(EAG_OP_GENERAL, EAG_MODE_INDIRECT);
        r.src_reg = 4'h3;
        @(negedge core_clk);
        req = r;
        @(negedge core_clk);
        `CHK(data_out.src_addr, 16'h1111)
        r.src_reg = 4'h4;
        req = r;
        @(negedge core_clk);
        `CHK(data_out.src_addr, 16'h2222)
        nrst = 1'b0;
        @(negedge core_clk);
        `CHK(data_out, '0)
        `CHK(prog_out, '0)
        nrst = 1'b1;
        req = '0;
        @(negedge core_clk);
        `CHK(data_out.valid, 1'b0)
    endtask : t_b2b_reset

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        req = '0;
        tpage = 8'h00;
        vpage = 8'h00;
        ccr = 16'h0000;
        mismatches = 0;
        tests_run = 0;
        cycles = 0;
        repeat (10) @(negedge core_clk);
        `CHK(data_out, '0)
        `CHK(prog_out, '0)
        nrst = 1'b1;
        t_file();
        t_modes();
        t_other();
        t_prog();
        t_b2b_reset();
        print_verdict();
    end

endmodule : test_eag_top
`default_nettype wire
